// ==== logic/ruc_pkg.sv ====
// constants and types shared by the remote upgrade control and status block
`default_nettype none
package ruc_pkg;
  // control register layout
  localparam int unsigned CTRL_WIDTH         = 39;
  localparam int unsigned CTRL_RSV_HIGH_POS  = 38;
  localparam int unsigned CTRL_EARLY_POS     = 37;
  localparam int unsigned CTRL_OSC_POS       = 36;
  localparam int unsigned CTRL_WATCHDOG_ENABLE_POS     = 35;
  localparam int unsigned CTRL_RSV_LOW_POS   = 34;
  localparam int unsigned CTRL_ADDR_MSB      = 33;
  localparam int unsigned CTRL_ADDR_LSB      = 12;
  localparam int unsigned CTRL_TIMER_MSB     = 11;
  localparam int unsigned CTRL_TIMER_LSB     = 0;
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 39'h00_0000_0000;

  // boot address and watchdog value forming
  localparam int unsigned BOOT_ADDR_WIDTH    = 24;
  localparam int unsigned ADDR_FIELD_WIDTH   = 22;
  localparam logic [1:0]  BOOT_ADDR_PAD      = 2'h0;
  localparam int unsigned WD_VALUE_WIDTH     = 29;
  localparam int unsigned WD_FIELD_WIDTH     = 12;
  localparam logic [16:0] WD_LOW_PATTERN     = 17'h00008;

  // power-up boot addresses per configuration scheme
  localparam logic [23:0] SERIAL_FACTORY_ADDR   = 24'h000000;
  localparam logic [23:0] PARALLEL_FACTORY_ADDR = 24'h010000;

  // status words
  localparam int unsigned STATUS_WIDTH       = 32;
  localparam int unsigned HISTORY_WIDTH      = 31;
  localparam int unsigned SRC_WIDTH          = 5;
  localparam logic [5:0]  STATUS_PAD         = 6'h00;
  // one-hot source bits inside the source field (field sits at history bits 30:26)
  localparam int unsigned SRC_EXT_RESET      = 4;
  localparam int unsigned SRC_CRC            = 3;
  localparam int unsigned SRC_STATUS         = 2;
  localparam int unsigned SRC_WATCHDOG       = 1;
  localparam int unsigned SRC_FABRIC         = 0;
  // returned instead of history before the first application image ran; value is arbitrary
  localparam logic [30:0] HISTORY_MARKER     = 31'h7fff_ffff;

  // master state codes reported in the status words
  localparam logic [1:0]  MS_FACTORY         = 2'h0;
  localparam logic [1:0]  MS_LOADING         = 2'h1;
  localparam logic [1:0]  MS_APPLICATION     = 2'h2;

  // read selector for a capture
  localparam logic [2:0]  SEL_INFO_FIRST     = 3'h0;
  localparam logic [2:0]  SEL_INFO_SECOND    = 3'h1;
  localparam logic [2:0]  SEL_HISTORY_FIRST  = 3'h2;
  localparam logic [2:0]  SEL_HISTORY_SECOND = 3'h3;
  localparam logic [2:0]  SEL_CONTROL        = 3'h4;
  localparam logic [2:0]  SEL_STATUS_SOURCE  = 3'h5;

  typedef enum logic [2:0] {
    RUC_ST_FACTORY = 3'b001,
    RUC_ST_LOADING = 3'b010,
    RUC_ST_APP     = 3'b100
  } ruc_state_e;
endpackage : ruc_pkg
`default_nettype wire

// ==== logic/ruc_watchdog_counter.sv ====
// down-counting user watchdog with reload and one-cycle expiry pulse
`timescale 1ns/1ps
`default_nettype none
module ruc_watchdog_counter #(
  parameter int unsigned WIDTH = 29
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_in,
  input  wire logic             run_in,
  input  wire logic             reload_in,
  input  wire logic [WIDTH-1:0] reload_value_in,
  output logic                  expired_out
);
  logic [WIDTH-1:0] count_reg;
  logic             armed_reg;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in || !run_in) begin
      count_reg <= '0;
      armed_reg <= 1'b0;
    end else if (reload_in || !armed_reg) begin
      count_reg <= reload_value_in;
      armed_reg <= 1'b1;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  // fires once; the block leaves user mode on expiry so no re-arm is needed here
  always_ff @(posedge clk_sys_in) begin
    if (rst_in || !run_in) begin
      expired_out <= 1'b0;
    end else begin
      expired_out <= armed_reg && !reload_in && (count_reg == {{(WIDTH-1){1'b0}}, 1'b1});
    end
  end
endmodule // ruc_watchdog_counter
`default_nettype wire

// ==== logic/ruc_upgrade_ctrl.sv ====
// remote configuration upgrade control, status and history registers with serial access
`timescale 1ns/1ps
`default_nettype none
// How it works
// - serial scheme: boot address zero at power-up
// - parallel scheme: boot address 010000 at power-up
// - test host may replace parallel factory address
// - control writable only from factory image
// - control bits: reserved, checks, enables, address, timeout
// - timeout is field followed by fixed pattern
// - boot address is field plus two zeros
// - early-done failure reloads the factory image
// - oscillator bit picks internal startup clock
// - status records the reconfiguration trigger
// - factory word: state, padding, boot address
// - application word one: state, enable, timeout
// - application word two: state, padding, address
// - two history records, current and previous image
// - history holds one-hot reconfiguration source field
// - simultaneous sources: highest bit wins
// - history holds leaving state and boot address
// - early history capture returns a marker
// - fabric trigger from factory image loads update, others clear
// - registers on system clock, at most 40 MHz
module ruc_upgrade_ctrl (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        parallel_active_scheme_in,
  input  wire logic        set_default_factory_boot_instr_in,
  input  wire logic [23:0] factory_boot_addr_in,
  input  wire logic        shift_enable_in,
  input  wire logic        capture_in,
  input  wire logic        update_in,
  input  wire logic [2:0]  read_select_in,
  input  wire logic        shift_data_in,
  output logic             shift_data_out,
  input  wire logic        config_reset_low_in,
  input  wire logic        reset_timer_low_in,
  input  wire logic        ext_config_reset_low_in,
  input  wire logic        ext_status_low_in,
  input  wire logic        crc_error_in,
  input  wire logic        configuration_done_in,
  input  wire logic        done_too_early_in,
  input  wire logic        image_invalid_in,
  output logic             reconfig_start_out,
  output logic [23:0]      load_address_out,
  output logic             load_factory_out,
  output logic [1:0]       master_state_out,
  output logic             startup_osc_internal_out,
  output logic             early_done_check_out,
  output logic             watchdog_timeout_out
);
  localparam int unsigned CW = ruc_pkg::CTRL_WIDTH;

  ruc_pkg::ruc_state_e state_reg;
  logic                target_app_reg;
  logic                init_done_reg;
  logic                app_seen_reg;
  logic [CW-1:0]       control_reg;
  logic [CW-1:0]       update_reg;
  logic [CW-1:0]       shift_reg;
  logic [23:0]         factory_addr_reg;
  logic [23:0]         current_boot_reg;
  logic [4:0]          status_src_reg;
  logic [30:0]         history_first_reg;
  logic [30:0]         history_second_reg;
  logic                fabric_prev_reg;
  logic                ext_reset_prev_reg;
  logic                status_prev_reg;
  logic                crc_prev_reg;

  // derived fields
  logic [23:0]         boot_addr;
  logic [28:0]         wd_value;
  logic                wd_enable;
  logic [1:0]          ms_code;
  logic                wd_expired;
  logic [4:0]          src_raw;
  logic [4:0]          src_sel;
  logic                trigger;
  logic                early_fail;
  logic [31:0]         info_first;
  logic [31:0]         info_second;
  logic [CW-1:0]       capture_value;
  logic [23:0]         factory_default;

  assign boot_addr = {control_reg[ruc_pkg::CTRL_ADDR_MSB:ruc_pkg::CTRL_ADDR_LSB],
                      ruc_pkg::BOOT_ADDR_PAD};
  assign wd_value  = {control_reg[ruc_pkg::CTRL_TIMER_MSB:ruc_pkg::CTRL_TIMER_LSB],
                      ruc_pkg::WD_LOW_PATTERN};
  assign wd_enable = control_reg[ruc_pkg::CTRL_WATCHDOG_ENABLE_POS];

  always_comb begin
    unique case (state_reg)
      ruc_pkg::RUC_ST_FACTORY: ms_code = ruc_pkg::MS_FACTORY;
      ruc_pkg::RUC_ST_LOADING: ms_code = ruc_pkg::MS_LOADING;
      ruc_pkg::RUC_ST_APP:     ms_code = ruc_pkg::MS_APPLICATION;
      default:                 ms_code = ruc_pkg::MS_FACTORY;
    endcase
  end

  // watchdog runs only while an application image is in user mode
  // reload follows the pin level, so a held reload keeps the count at its start
  ruc_watchdog_counter #(
    .WIDTH(ruc_pkg::WD_VALUE_WIDTH)
  ) u_watchdog (
    .clk_sys_in      (clk_sys_in),
    .rst_in          (rst_in),
    .run_in          ((state_reg == ruc_pkg::RUC_ST_APP) && wd_enable),
    .reload_in       (!reset_timer_low_in),
    .reload_value_in (wd_value),
    .expired_out     (wd_expired)
  );

  // events are taken on their assertion edge so a held level does not retrigger
  // prev registers reset to the idle pin levels, so no false edge follows reset
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      fabric_prev_reg    <= 1'b1;
      ext_reset_prev_reg <= 1'b1;
      status_prev_reg    <= 1'b1;
      crc_prev_reg       <= 1'b0;
    end else begin
      fabric_prev_reg    <= config_reset_low_in;
      ext_reset_prev_reg <= ext_config_reset_low_in;
      status_prev_reg    <= ext_status_low_in;
      crc_prev_reg       <= crc_error_in;
    end
  end

  always_comb begin
    src_raw = '0;
    src_raw[ruc_pkg::SRC_EXT_RESET] = ext_reset_prev_reg && !ext_config_reset_low_in;
    src_raw[ruc_pkg::SRC_CRC]       = !crc_prev_reg && crc_error_in;
    src_raw[ruc_pkg::SRC_STATUS]    = status_prev_reg && !ext_status_low_in;
    src_raw[ruc_pkg::SRC_WATCHDOG]  = wd_expired;
    src_raw[ruc_pkg::SRC_FABRIC]    = fabric_prev_reg && !config_reset_low_in;
  end

  // keep only the highest pending source
  always_comb begin
    src_sel = '0;
    for (int i = ruc_pkg::SRC_WIDTH - 1; i >= 0; i--) begin
      if (src_raw[i] && (src_sel == '0)) begin
        src_sel[i] = 1'b1;
      end
    end
  end

  // an event before init is dropped: strap and defaults are not settled yet
  assign trigger    = init_done_reg && (src_raw != '0);
  // early-done failure keeps the status source: a load fault, not a trigger
  assign early_fail = (state_reg == ruc_pkg::RUC_ST_LOADING) && target_app_reg &&
                      control_reg[ruc_pkg::CTRL_EARLY_POS] &&
                      (image_invalid_in || done_too_early_in);

  // parallel factory address is replaceable by the test host
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      factory_addr_reg <= ruc_pkg::PARALLEL_FACTORY_ADDR;
    end else if (set_default_factory_boot_instr_in) begin
      factory_addr_reg <= factory_boot_addr_in;
    end
  end

  // the scheme strap is not latched: it is read on the first edge after reset release and again at every factory load
  assign factory_default = parallel_active_scheme_in ? factory_addr_reg
                                                     : ruc_pkg::SERIAL_FACTORY_ADDR;

  // control register: loaded from the update register on a fabric trigger in the factory image, cleared by other triggers and early-done failures
  // reserved bits travel with the update word; they steer nothing here
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      control_reg <= ruc_pkg::CTRL_RESET;
    end else if (!init_done_reg) begin
      control_reg <= ruc_pkg::CTRL_RESET;
      control_reg[ruc_pkg::CTRL_ADDR_MSB:ruc_pkg::CTRL_ADDR_LSB] <=
        factory_default[23:2];
    end else if (trigger) begin
      if (src_sel[ruc_pkg::SRC_FABRIC] && (state_reg == ruc_pkg::RUC_ST_FACTORY)) begin
        control_reg <= update_reg;
      end else begin
        control_reg <= ruc_pkg::CTRL_RESET;
      end
    end else if (early_fail) begin
      control_reg <= ruc_pkg::CTRL_RESET;
    end
  end

  // master state machine
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_reg      <= ruc_pkg::RUC_ST_FACTORY;
      target_app_reg <= 1'b0;
      init_done_reg  <= 1'b0;
      app_seen_reg   <= 1'b0;
    end else begin
      init_done_reg <= 1'b1;
      if (trigger) begin
        state_reg      <= ruc_pkg::RUC_ST_LOADING;
        // a fabric trigger from an application image goes back to the factory image
        target_app_reg <= src_sel[ruc_pkg::SRC_FABRIC] && (state_reg == ruc_pkg::RUC_ST_FACTORY);
      end else if (early_fail) begin
        target_app_reg <= 1'b0;
      end else begin
        unique case (state_reg)
          ruc_pkg::RUC_ST_LOADING: begin
            if (configuration_done_in) begin
              state_reg <= target_app_reg ? ruc_pkg::RUC_ST_APP : ruc_pkg::RUC_ST_FACTORY;
              if (target_app_reg) begin
                app_seen_reg <= 1'b1;
              end
            end
          end
          ruc_pkg::RUC_ST_FACTORY,
          ruc_pkg::RUC_ST_APP: begin
            state_reg <= state_reg;
          end
          default: begin
            state_reg <= ruc_pkg::RUC_ST_FACTORY;
          end
        endcase
      end
    end
  end

  // load request toward the configuration engine
  // factory loads use the strap default, never the cleared control word
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      reconfig_start_out <= 1'b0;
      load_address_out   <= '0;
      load_factory_out   <= 1'b1;
      current_boot_reg   <= '0;
    end else if (!init_done_reg) begin
      reconfig_start_out <= 1'b0;
      current_boot_reg   <= factory_default;
      load_address_out   <= factory_default;
      load_factory_out   <= 1'b1;
    end else if (trigger || early_fail) begin
      reconfig_start_out <= 1'b1;
      if (trigger && src_sel[ruc_pkg::SRC_FABRIC] && (state_reg == ruc_pkg::RUC_ST_FACTORY)) begin
        load_address_out <= {update_reg[ruc_pkg::CTRL_ADDR_MSB:ruc_pkg::CTRL_ADDR_LSB],
                             ruc_pkg::BOOT_ADDR_PAD};
        current_boot_reg <= {update_reg[ruc_pkg::CTRL_ADDR_MSB:ruc_pkg::CTRL_ADDR_LSB],
                             ruc_pkg::BOOT_ADDR_PAD};
        load_factory_out <= 1'b0;
      end else begin
        load_address_out <= factory_default;
        current_boot_reg <= factory_default;
        load_factory_out <= 1'b1;
      end
    end else begin
      reconfig_start_out <= 1'b0;
    end
  end

  // startup option bits steer the configuration engine while an image loads
  // registered copies of the control bits; an early-done failure clears them during the load
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      startup_osc_internal_out <= 1'b0;
      early_done_check_out     <= 1'b0;
      master_state_out         <= ruc_pkg::MS_FACTORY;
      watchdog_timeout_out     <= 1'b0;
    end else begin
      startup_osc_internal_out <= control_reg[ruc_pkg::CTRL_OSC_POS];
      early_done_check_out     <= control_reg[ruc_pkg::CTRL_EARLY_POS];
      master_state_out         <= ms_code;
      watchdog_timeout_out     <= wd_expired;
    end
  end

  // trigger cause and history of application images
  // history moves only when an application image is left; factory exits are not kept
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      status_src_reg     <= '0;
      history_first_reg  <= '0;
      history_second_reg <= '0;
    end else if (trigger) begin
      status_src_reg <= src_sel;
      if (state_reg == ruc_pkg::RUC_ST_APP) begin
        history_second_reg <= history_first_reg;
        history_first_reg  <= {src_sel, ms_code, current_boot_reg};
      end
    end
  end

  // status words
  // outside an application image both words give the factory layout
  assign info_first  = (state_reg == ruc_pkg::RUC_ST_APP) ?
                       {ms_code, wd_enable, wd_value} :
                       {ms_code, ruc_pkg::STATUS_PAD, current_boot_reg};
  assign info_second = {ms_code, ruc_pkg::STATUS_PAD, current_boot_reg};

  // unused select codes read as zero so a stray capture shifts out a clean word
  always_comb begin
    capture_value = '0;
    unique case (read_select_in)
      ruc_pkg::SEL_INFO_FIRST:  capture_value[31:0] = info_first;
      ruc_pkg::SEL_INFO_SECOND: capture_value[31:0] = (state_reg == ruc_pkg::RUC_ST_APP) ?
                                                      info_second : info_first;
      ruc_pkg::SEL_HISTORY_FIRST:
        capture_value[30:0] = app_seen_reg ? history_first_reg : ruc_pkg::HISTORY_MARKER;
      ruc_pkg::SEL_HISTORY_SECOND:
        capture_value[30:0] = app_seen_reg ? history_second_reg : ruc_pkg::HISTORY_MARKER;
      ruc_pkg::SEL_CONTROL:
        capture_value = (state_reg == ruc_pkg::RUC_ST_FACTORY) ? update_reg : control_reg;
      ruc_pkg::SEL_STATUS_SOURCE: capture_value[4:0] = status_src_reg;
      default:                  capture_value = '0;
    endcase
  end

  // serial shift register: capture wins over shift, lsb goes out first
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      shift_reg <= '0;
    end else if (capture_in) begin
      shift_reg <= capture_value;
    end else if (shift_enable_in) begin
      shift_reg <= {shift_data_in, shift_reg[CW-1:1]};
    end
  end

  assign shift_data_out = shift_reg[0];

  // update register takes the shifted word only in a factory image; reserved bits kept as written
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      update_reg <= ruc_pkg::CTRL_RESET;
    end else if (update_in && (state_reg == ruc_pkg::RUC_ST_FACTORY)) begin
      update_reg <= shift_reg;
    end
  end
endmodule // ruc_upgrade_ctrl
`default_nettype wire

// ==== verification/ruc_upgrade_ctrl_chk.sv ====
// concurrent checks on the ports of the upgrade control block
`timescale 1ns/1ps
`default_nettype none
module ruc_upgrade_ctrl_chk (
  input wire logic        clk_sys_in,
  input wire logic        rst_in,
  input wire logic        config_reset_low_in,
  input wire logic        crc_error_in,
  input wire logic        reconfig_start_out,
  input wire logic [23:0] load_address_out,
  input wire logic        load_factory_out,
  input wire logic [1:0]  master_state_out,
  input wire logic        watchdog_timeout_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  sequence s_single_pulse;
    reconfig_start_out ##1 !reconfig_start_out;
  endsequence
  sequence s_enter_loading;
    ##[0:2] master_state_out == ruc_pkg::MS_LOADING;
  endsequence

  a_start_one_cycle: assert property (reconfig_start_out |-> s_single_pulse)
    else $error("reconfiguration start longer than one cycle");
  a_fabric_trigger: assert property (
    ($fell(config_reset_low_in) && master_state_out == ruc_pkg::MS_FACTORY) |-> ##[1:3] reconfig_start_out)
    else $error("fabric trigger did not start reconfiguration");
  a_crc_trigger: assert property (
    ($rose(crc_error_in) && master_state_out == ruc_pkg::MS_APPLICATION) |-> ##[1:3] reconfig_start_out)
    else $error("crc error did not start reconfiguration");
  a_start_loading: assert property (reconfig_start_out |-> s_enter_loading)
    else $error("reconfiguration did not enter loading");
  a_address_pad: assert property (reconfig_start_out |-> load_address_out[1:0] == 2'h0)
    else $error("boot address low bits not zero");
  a_wd_one_cycle: assert property (watchdog_timeout_out |=> !watchdog_timeout_out)
    else $error("watchdog pulse longer than one cycle");
  a_wd_app_only: assert property (
    watchdog_timeout_out |-> $past(master_state_out) == ruc_pkg::MS_APPLICATION)
    else $error("watchdog expired outside application");
  a_wd_reconfig: assert property (watchdog_timeout_out |-> ##[0:3] reconfig_start_out)
    else $error("watchdog expiry did not reconfigure");
  a_state_code: assert property (master_state_out != 2'h3)
    else $error("unused master state code");
  a_app_locked: assert property (
    (master_state_out == ruc_pkg::MS_APPLICATION && !reconfig_start_out)
    |=> ($stable(load_address_out) || reconfig_start_out))
    else $error("boot address changed in application");
  a_app_from_factory: assert property (
    (reconfig_start_out && !load_factory_out) |-> $past(master_state_out) != ruc_pkg::MS_APPLICATION)
    else $error("application load requested outside the factory image");
endmodule // ruc_upgrade_ctrl_chk

bind ruc_upgrade_ctrl ruc_upgrade_ctrl_chk u_ruc_upgrade_ctrl_chk (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .config_reset_low_in(config_reset_low_in),
  .crc_error_in(crc_error_in), .reconfig_start_out(reconfig_start_out), .load_address_out(load_address_out),
  .load_factory_out(load_factory_out), .master_state_out(master_state_out),
  .watchdog_timeout_out(watchdog_timeout_out));
`default_nettype wire

// ==== verification/ruc_fabric_model.sv ====
// fabric user logic model driving the serial access port
`timescale 1ns/1ps
`default_nettype none
module ruc_fabric_model (
  input  wire logic       clk_sys_in,
  input  wire logic       shift_data_out_in,
  output logic            shift_enable_out,
  output logic            capture_out,
  output logic            update_out,
  output logic [2:0]      read_select_out,
  output logic            shift_data_in_out
);
  initial begin
    shift_enable_out = 1'b0;
    capture_out = 1'b0;
    update_out = 1'b0;
    read_select_out = 3'h0;
    shift_data_in_out = 1'b0;
  end
  // lsb comes out first; sampled before the edge's own shift lands
  task automatic read_word(input logic [2:0] sel, output logic [38:0] w);
    @(posedge clk_sys_in);
    capture_out <= 1'b1;
    read_select_out <= sel;
    @(posedge clk_sys_in);
    capture_out <= 1'b0;
    shift_enable_out <= 1'b1;
    for (int i = 0; i < 39; i++) begin
      @(posedge clk_sys_in);
      w[i] = shift_data_out_in;
    end
    shift_enable_out <= 1'b0;
  endtask
  // bit 0 enters first so it ends at the bottom after 39 shifts
  task automatic write_word(input logic [38:0] w);
    @(posedge clk_sys_in);
    shift_enable_out <= 1'b1;
    shift_data_in_out <= w[0];
    for (int i = 1; i < 39; i++) begin
      @(posedge clk_sys_in);
      shift_data_in_out <= w[i];
    end
    @(posedge clk_sys_in);
    shift_enable_out <= 1'b0;
    update_out <= 1'b1;
    // released data line shows the inverse of the last bit
    shift_data_in_out <= ~w[38];
    @(posedge clk_sys_in);
    update_out <= 1'b0;
  endtask
endmodule // ruc_fabric_model
`default_nettype wire

// ==== verification/tb.sv ====
// self-checking bench for the upgrade control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk_sys_in, rst_in, strap, instr, cfg_low, rtl_low, xr_low, xs_low, crc, done;
  logic        shen, cap, upd, sdi, sdo, start, ldf, osc, early, wdt, tearly, inval;
  logic [2:0]  sel;
  logic [23:0] fba, lda;
  logic [1:0]  mso;
  int          errors, compares, cycles;
  // both option bits on, reserved bits set to prove they are kept
  localparam logic [38:0] W1 = {5'h1f, 22'h000123, 12'hab5};
  localparam logic [38:0] W2 = {5'h1e, 22'h000200, 12'h000};
  localparam logic [30:0] H1 = {5'h08, ruc_pkg::MS_APPLICATION, 22'h000123, 2'h0};

  ruc_fabric_model u_ruc_fabric_model (.clk_sys_in(clk_sys_in), .shift_data_out_in(sdo), .shift_enable_out(shen),
    .capture_out(cap), .update_out(upd), .read_select_out(sel), .shift_data_in_out(sdi));
  ruc_upgrade_ctrl u_ruc_upgrade_ctrl (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .parallel_active_scheme_in(strap),
    .set_default_factory_boot_instr_in(instr), .factory_boot_addr_in(fba), .shift_enable_in(shen),
    .capture_in(cap), .update_in(upd), .read_select_in(sel), .shift_data_in(sdi), .shift_data_out(sdo),
    .config_reset_low_in(cfg_low), .reset_timer_low_in(rtl_low), .ext_config_reset_low_in(xr_low),
    .ext_status_low_in(xs_low), .crc_error_in(crc), .configuration_done_in(done), .done_too_early_in(tearly),
    .image_invalid_in(inval), .reconfig_start_out(start), .load_address_out(lda), .load_factory_out(ldf),
    .master_state_out(mso), .startup_osc_internal_out(osc), .early_done_check_out(early),
    .watchdog_timeout_out(wdt));

  initial begin
    {clk_sys_in, strap, instr, crc, done, tearly, inval, errors, compares, cycles} = '0;
    {rst_in, cfg_low, rtl_low, xr_low, xs_low} = 5'h1f;
    fba = 24'h000000;
    // 50 ns period, below the 40 MHz ceiling of the shift path
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  task automatic wrap_up();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 8000) begin
      errors++;
      $display("[ERR] run length expected below 8000 seen 8000");
      wrap_up();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  task automatic chk(input string n, input logic [38:0] e, input logic [38:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [2:0] s, input logic [38:0] e, input string n);
    logic [38:0] w;
    u_ruc_fabric_model.read_word(s, w);
    chk(n, e, w);
  endtask
  task automatic do_reset();
    rst_in <= 1'b1;
    tick(2);
    rst_in <= 1'b0;
    tick(3);
  endtask
  // low for six cycles covers the 250 ns minimum
  task automatic fab_trig();
    cfg_low <= 1'b0;
    tick(6);
    cfg_low <= 1'b1;
  endtask
  task automatic finish_load(input int tail);
    tick(4);
    done <= 1'b1;
    tick(2);
    done <= 1'b0;
    tick(tail);
  endtask

  initial begin
    @(posedge clk_sys_in);
    do_reset();
    chk("serial boot address", ruc_pkg::SERIAL_FACTORY_ADDR, lda);
    chk("factory load", 1'b1, ldf);
    rd(ruc_pkg::SEL_HISTORY_FIRST, ruc_pkg::HISTORY_MARKER, "early history");
    rd(ruc_pkg::SEL_INFO_FIRST, {ruc_pkg::MS_FACTORY, ruc_pkg::STATUS_PAD, 24'h0}, "factory word");
    $display("test reset and factory status done");
    u_ruc_fabric_model.write_word(W1);
    rd(ruc_pkg::SEL_CONTROL, W1, "update word");
    fab_trig();
    chk("application address", {22'h000123, ruc_pkg::BOOT_ADDR_PAD}, lda);
    finish_load(3);
    chk("master state", ruc_pkg::MS_APPLICATION, mso);
    chk("oscillator select", 1'b1, osc);
    chk("early done check", 1'b1, early);
    rd(ruc_pkg::SEL_INFO_FIRST, {ruc_pkg::MS_APPLICATION, 1'b1, 12'hab5, ruc_pkg::WD_LOW_PATTERN},
       "app word one");
    rd(ruc_pkg::SEL_INFO_SECOND, {ruc_pkg::MS_APPLICATION, 6'h00, 22'h000123, 2'h0}, "app word two");
    u_ruc_fabric_model.write_word(~W1);
    rd(ruc_pkg::SEL_CONTROL, W1, "control locked");
    rtl_low <= 1'b0;
    tick(6);
    rtl_low <= 1'b1;
    // crc and status arrive together; crc holds the higher bit
    crc <= 1'b1;
    xs_low <= 1'b0;
    tick(6);
    crc <= 1'b0;
    xs_low <= 1'b1;
    finish_load(3);
    chk("cleared address", 24'h000000, lda);
    rd(ruc_pkg::SEL_HISTORY_FIRST, H1, "crc history");
    rd(ruc_pkg::SEL_STATUS_SOURCE, 39'h08, "crc status source");
    $display("test application entry and crc exit done");
    u_ruc_fabric_model.write_word(W2);
    fab_trig();
    finish_load(0);
    for (int i = 0; i < 100 && wdt !== 1'b1; i++)
      tick(1);
    chk("watchdog expiry", 1'b1, wdt);
    finish_load(3);
    rd(ruc_pkg::SEL_HISTORY_FIRST, {5'h02, ruc_pkg::MS_APPLICATION, 22'h000200, 2'h0},
       "watchdog history");
    rd(ruc_pkg::SEL_HISTORY_SECOND, H1, "older history");
    $display("test watchdog and history done");
    // each early-done fault in turn sends the load back to the factory image
    for (int k = 0; k < 2; k++) begin
      fab_trig();
      {tearly, inval} <= (k == 0) ? 2'h2 : 2'h1;
      tick(2);
      {tearly, inval} <= 2'h0;
      chk("early fail factory load", 1'b1, ldf);
      chk("early fail address", ruc_pkg::SERIAL_FACTORY_ADDR, lda);
      finish_load(3);
      chk("early fail state", ruc_pkg::MS_FACTORY, mso);
    end
    $display("test early done faults done");
    strap <= 1'b1;
    do_reset();
    chk("parallel boot address", ruc_pkg::PARALLEL_FACTORY_ADDR, lda);
    instr <= 1'b1;
    fba <= 24'h2a0000;
    tick(1);
    instr <= 1'b0;
    xr_low <= 1'b0;
    tick(6);
    xr_low <= 1'b1;
    tick(2);
    chk("replaced boot address", 24'h2a0000, lda);
    rd(ruc_pkg::SEL_STATUS_SOURCE, 39'h10, "reset status source");
    $display("test parallel scheme done");
    wrap_up();
  end
endmodule // tb
`default_nettype wire
